// ### core/eac_cfg.svh
// Register map, field positions, reset values and thresholds of the energy block
`ifndef EAC_CFG_SVH
`define EAC_CFG_SVH

// Register offsets
`define EAC_OFF_ACTEN      6'h01
`define EAC_OFF_ACTRC      6'h02
`define EAC_OFF_LNACT      6'h03
`define EAC_OFF_LNAPP      6'h04
`define EAC_OFF_MEAS       6'h0B
`define EAC_OFF_WAVE       6'h0C
`define EAC_OFF_WATT       6'h0D
`define EAC_OFF_IRQEN      6'h10
`define EAC_OFF_STATUS     6'h11
`define EAC_OFF_HCNT       6'h12
`define EAC_OFF_OPTION     6'h18

// Field positions
`define EAC_OPT_CREEP_DIS  3
`define EAC_OPT_ABS_SUM    2
`define EAC_WAV_REACTIVE   5
`define EAC_MEAS_ZC_LO     4
`define EAC_MEAS_ZC_HI     6
`define EAC_WAT_MOD_HI     7
`define EAC_WAT_MOD_LO     6
`define EAC_WAT_SEL_HI     5
`define EAC_WAT_SEL_LO     3
`define EAC_STAT_LINE_DONE 0
`define EAC_IRQEN_LINE     0

// Reset values
`define EAC_RST_BYTE       8'h00
`define EAC_RST_HCNT       16'hFFFF

// Creep threshold: 0.005 % of full scale 13,743,895 is 687
`define EAC_PWR_FULLSCALE  24'hD1B717
`define EAC_CREEP_THRESH   24'h0002AF

// Line accumulator weight: four times the active energy LSB
`define EAC_LINE_SHIFT     2
`endif

// ### core/eac_pkg.sv
// Types shared by the energy accumulation control block
package eac_pkg;
    typedef logic signed [23:0] eac_pwr_t;
    typedef logic signed [47:0] eac_acc_t;
    typedef enum logic [1:0] {
        EAC_COMBO_STAR  = 2'h0,
        EAC_COMBO_DELTA = 2'h1,
        EAC_COMBO_MIXED = 2'h2,
        EAC_COMBO_RSVD  = 2'h3
    } eac_combo_t;
endpackage : eac_pkg

// ### core/eac_core.sv
// Energy accumulation control: creep gate, summation, line-cycle accumulation
// Overview of operation
// - Creep gate on at reset; option bit3 disables
// - Each phase below threshold adds no energy
// - Threshold is 687 of full-scale 13,743,895
// - Option bit2: one absolute sum, zero signed
// - Sum mode drives the active and line accumulators and pulse, not the redirected active sum
// - Absolute mode adds every phase as positive
// - Reverse power flags any negative phase always
// - Line accumulation always runs, no enable
// - Mode bits 4-6 pick counting phases A-C
// - Picked phase also enables its crossing logic
// - Unsigned 16-bit half-cycle target, up to 65535
// - Period end sets flag; IRQ if enabled
// - Two-bit combination field picks line formula
// - Three term bits include or exclude terms
// - Line accumulator weighs four times active accumulator
// - Waveform bit5 moves active to apparent line acc
// - Redirected active sum ignores the sign
// - Term bits select phases in reactive mode
// - Reactive: voltage times shifted current, low-pass
`include "eac_cfg.svh"
module eac_core #(
    parameter int SMP_W    = 16,
    parameter int LPF_SHFT = 4,
    parameter int PLS_BIT  = 24
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // Register port
    input  wire logic                    reg_wr_en,
    input  wire logic                    reg_rd_en,
    input  wire logic [5:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    output logic      [23:0]             reg_rdata,
    output logic                         reg_rvalid,
    // Samples, one set per sample strobe
    input  wire logic                    sample_en,
    input  wire logic signed [SMP_W-1:0] volt_a,
    input  wire logic signed [SMP_W-1:0] volt_b,
    input  wire logic signed [SMP_W-1:0] volt_c,
    input  wire logic signed [SMP_W-1:0] curr_a,
    input  wire logic signed [SMP_W-1:0] curr_b,
    input  wire logic signed [SMP_W-1:0] curr_c,
    input  wire logic signed [SMP_W-1:0] curr_shift_a,
    input  wire logic signed [SMP_W-1:0] curr_shift_b,
    input  wire logic signed [SMP_W-1:0] curr_shift_c,
    input  wire logic        [23:0]      apparent_total,
    // Zero-crossing detector
    input  wire logic [2:0]              zc_pulse,
    output logic      [2:0]              zc_enable,
    // Status outputs
    output logic                         reverse_power,
    output logic                         calibration_pulse_out,
    output logic                         irq_n_o,
    output logic                         irq_n_oe
);
    // Control registers
    logic [7:0]  meas_r;
    logic [7:0]  wave_r;
    logic [7:0]  watt_r;
    logic [7:0]  option_r;
    logic [7:0]  irqen_r;
    logic [15:0] hc_tgt_r;
    logic        line_done_r;
    // Accumulators
    eac_pkg::eac_acc_t act_acc_r;
    eac_pkg::eac_acc_t line_act_r;
    eac_pkg::eac_acc_t line_va_r;
    logic [23:0]       line_act_latch_r;
    logic [23:0]       line_va_latch_r;
    logic [16:0]       hc_cnt_r;
    logic              pls_prev_r;

    // Decoded fields
    eac_pkg::eac_combo_t combo;
    logic [2:0]  term_sel;
    logic        creep_en;
    logic        abs_mode;
    logic        react_mode;
    assign combo      = eac_pkg::eac_combo_t'(watt_r[`EAC_WAT_MOD_HI:`EAC_WAT_MOD_LO]);
    assign term_sel   = watt_r[`EAC_WAT_SEL_HI:`EAC_WAT_SEL_LO];
    assign creep_en   = !option_r[`EAC_OPT_CREEP_DIS];
    assign abs_mode   = option_r[`EAC_OPT_ABS_SUM];
    assign react_mode = wave_r[`EAC_WAV_REACTIVE];

    // Per-term operands selected by the combination field
    logic signed [SMP_W-1:0] volt_v [3];
    logic signed [SMP_W-1:0] shft_v [3];
    logic signed [SMP_W:0]   curr_v [3];
    logic        [2:0]       term_on;
    always_comb
    begin
        volt_v[0] = volt_a;
        volt_v[1] = volt_b;
        volt_v[2] = volt_c;
        shft_v[0] = curr_shift_a;
        shft_v[1] = curr_shift_b;
        shft_v[2] = curr_shift_c;
        curr_v[0] = {curr_a[SMP_W-1], curr_a};
        curr_v[1] = {curr_b[SMP_W-1], curr_b};
        curr_v[2] = {curr_c[SMP_W-1], curr_c};
        term_on   = term_sel;
        unique case (combo)
            eac_pkg::EAC_COMBO_DELTA:
            begin
                curr_v[0] = curr_a - curr_b;
                curr_v[2] = curr_c - curr_b;
                term_on[1] = 1'b0;
            end
            eac_pkg::EAC_COMBO_MIXED:
            begin
                curr_v[0] = curr_a - curr_b;
                term_on[1] = 1'b0;
            end
            default:
            begin
                curr_v[0] = {curr_a[SMP_W-1], curr_a};
            end
        endcase
    end

    // Per-term power paths: product, low-pass, creep gate
    eac_pkg::eac_pwr_t p_flt_r [3];
    eac_pkg::eac_pwr_t q_flt_r [3];
    logic signed [25:0] p_gate [3];
    logic signed [25:0] p_abs  [3];
    logic signed [25:0] q_ext  [3];
    logic [2:0]         p_neg;
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_term
            logic signed [2*SMP_W:0]   p_prod;
            logic signed [2*SMP_W-1:0] q_prod;
            logic signed [24:0]        p_diff;
            logic signed [24:0]        q_diff;
            logic        [23:0]        p_mag;
            assign p_prod = volt_v[g] * curr_v[g];
            assign q_prod = volt_v[g] * shft_v[g];
            assign p_diff = 25'(signed'(p_prod[2*SMP_W-1:SMP_W-8])) - 25'(p_flt_r[g]);
            assign q_diff = 25'(signed'(q_prod[2*SMP_W-1:SMP_W-8])) - 25'(q_flt_r[g]);
            assign p_mag  = p_flt_r[g][23] ? 24'(-p_flt_r[g]) : p_flt_r[g];
            assign p_neg[g]  = p_flt_r[g][23];
            // Creep gate judged per phase
            assign p_gate[g] = (creep_en && p_mag < `EAC_CREEP_THRESH) ? 26'sh0
                             : 26'(p_flt_r[g]);
            assign p_abs[g]  = p_gate[g][25] ? -p_gate[g] : p_gate[g];
            assign q_ext[g]  = 26'(q_flt_r[g]);
            // First-order low-pass extracts the dc power
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    p_flt_r[g] <= 24'sh000000;
                    q_flt_r[g] <= 24'sh000000;
                end
                else if (sample_en)
                begin
                    p_flt_r[g] <= p_flt_r[g] + 24'(p_diff >>> LPF_SHFT);
                    q_flt_r[g] <= q_flt_r[g] + 24'(q_diff >>> LPF_SHFT);
                end
            end
        end
    endgenerate

    // Totals for each accumulator
    logic signed [27:0] act_sum;
    logic signed [27:0] line_p_sum;
    logic signed [27:0] line_pabs_sum;
    logic signed [27:0] line_q_sum;
    always_comb
    begin
        act_sum       = 28'sh0;
        line_p_sum    = 28'sh0;
        line_pabs_sum = 28'sh0;
        line_q_sum    = 28'sh0;
        for (int k = 0; k < 3; k++)
        begin
            act_sum = act_sum + 28'(abs_mode ? p_abs[k] : p_gate[k]);
            if (term_on[k])
            begin
                line_p_sum    = line_p_sum + 28'(abs_mode ? p_abs[k] : p_gate[k]);
                line_pabs_sum = line_pabs_sum + 28'(p_abs[k]);
                line_q_sum    = line_q_sum + 28'(q_ext[k]);
            end
        end
    end

    // Half-cycle counting over the selected phases
    logic [2:0]  zc_sel;
    logic [1:0]  zc_cnt;
    logic [16:0] hc_sum;
    logic        period_end;
    assign zc_sel     = zc_pulse & meas_r[`EAC_MEAS_ZC_HI:`EAC_MEAS_ZC_LO];
    assign zc_cnt     = 2'(zc_sel[0]) + 2'(zc_sel[1]) + 2'(zc_sel[2]);
    assign hc_sum     = hc_cnt_r + 17'(zc_cnt);
    assign period_end = (hc_tgt_r != 16'h0000) && (hc_sum >= 17'(hc_tgt_r));

    // Register writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meas_r    <= `EAC_RST_BYTE;
            wave_r    <= `EAC_RST_BYTE;
            watt_r    <= `EAC_RST_BYTE;
            option_r  <= `EAC_RST_BYTE;
            irqen_r   <= `EAC_RST_BYTE;
            hc_tgt_r  <= `EAC_RST_HCNT;
        end
        else if (reg_wr_en)
        begin
            unique case (reg_addr)
                `EAC_OFF_MEAS:    meas_r    <= reg_wdata;
                `EAC_OFF_WAVE:    wave_r    <= reg_wdata;
                `EAC_OFF_WATT:    watt_r    <= reg_wdata;
                `EAC_OFF_OPTION:  option_r  <= reg_wdata;
                `EAC_OFF_IRQEN:   irqen_r   <= reg_wdata;
                `EAC_OFF_HCNT:    hc_tgt_r  <= {hc_tgt_r[7:0], reg_wdata};
                default:          ;
            endcase
        end
    end

    // Active energy accumulator, cleared by reading the read-clear view
    logic rd_clear;
    assign rd_clear = reg_rd_en && (reg_addr == `EAC_OFF_ACTRC);
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            act_acc_r <= 48'sh0;
        else if (rd_clear)
            act_acc_r <= sample_en ? 48'(act_sum) : 48'sh0;
        else if (sample_en)
            act_acc_r <= act_acc_r + 48'(act_sum);
    end

    // Line accumulators: always running, latched and restarted per period
    logic signed [47:0] line_act_add;
    logic signed [47:0] line_va_add;
    logic signed [47:0] line_act_nxt;
    logic signed [47:0] line_va_nxt;
    always_comb
    begin
        if (react_mode)
        begin
            line_act_add = 48'(line_q_sum) <<< `EAC_LINE_SHIFT;
            line_va_add  = 48'(line_pabs_sum) <<< `EAC_LINE_SHIFT;
        end
        else
        begin
            line_act_add = 48'(line_p_sum) <<< `EAC_LINE_SHIFT;
            line_va_add  = 48'({1'b0, apparent_total});
        end
        line_act_nxt = line_act_r + (sample_en ? line_act_add : 48'sh0);
        line_va_nxt  = line_va_r + (sample_en ? line_va_add : 48'sh0);
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            line_act_r       <= 48'sh0;
            line_va_r        <= 48'sh0;
            line_act_latch_r <= 24'h000000;
            line_va_latch_r  <= 24'h000000;
        end
        else if (period_end)
        begin
            line_act_latch_r <= line_act_nxt[47:24];
            line_va_latch_r  <= line_va_nxt[47:24];
            line_act_r       <= 48'sh0;
            line_va_r        <= 48'sh0;
        end
        else
        begin
            line_act_r <= line_act_nxt;
            line_va_r  <= line_va_nxt;
        end
    end

    // Half-cycle counter keeps crossings beyond the target
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            hc_cnt_r <= 17'h00000;
        else if (hc_tgt_r == 16'h0000)
            hc_cnt_r <= 17'h00000;
        else if (period_end)
            hc_cnt_r <= hc_sum - 17'(hc_tgt_r);
        else
            hc_cnt_r <= hc_sum;
    end

    // Line-done flag: a new period end wins over a status read
    logic stat_rd;
    assign stat_rd = reg_rd_en && (reg_addr == `EAC_OFF_STATUS);
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            line_done_r <= 1'b0;
        else if (period_end)
            line_done_r <= 1'b1;
        else if (stat_rd)
            line_done_r <= 1'b0;
    end

    // Open-drain request, pulled low while flag and enable are set
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_n_o  <= 1'b0;
            irq_n_oe <= 1'b0;
        end
        else
        begin
            irq_n_o  <= 1'b0;
            irq_n_oe <= line_done_r && irqen_r[`EAC_IRQEN_LINE];
        end
    end

    // Phase enables, reverse power and calibration pulse
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zc_enable             <= 3'h0;
            reverse_power         <= 1'b0;
            calibration_pulse_out <= 1'b0;
            pls_prev_r            <= 1'b0;
        end
        else
        begin
            zc_enable             <= meas_r[`EAC_MEAS_ZC_HI:`EAC_MEAS_ZC_LO];
            reverse_power         <= |p_neg;
            pls_prev_r            <= act_acc_r[PLS_BIT];
            calibration_pulse_out <= pls_prev_r != act_acc_r[PLS_BIT];
        end
    end

    // Register reads, answered one cycle later
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata  <= 24'h000000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= reg_rd_en;
            if (reg_rd_en)
            begin
                unique case (reg_addr)
                    `EAC_OFF_ACTEN:     reg_rdata <= act_acc_r[47:24];
                    `EAC_OFF_ACTRC:     reg_rdata <= act_acc_r[47:24];
                    `EAC_OFF_LNACT:     reg_rdata <= line_act_latch_r;
                    `EAC_OFF_LNAPP:     reg_rdata <= line_va_latch_r;
                    `EAC_OFF_MEAS:      reg_rdata <= {16'h0000, meas_r};
                    `EAC_OFF_WAVE:      reg_rdata <= {16'h0000, wave_r};
                    `EAC_OFF_WATT:      reg_rdata <= {16'h0000, watt_r};
                    `EAC_OFF_OPTION:    reg_rdata <= {16'h0000, option_r};
                    `EAC_OFF_IRQEN:     reg_rdata <= {16'h0000, irqen_r};
                    `EAC_OFF_STATUS:    reg_rdata <= {23'h000000, line_done_r};
                    `EAC_OFF_HCNT:      reg_rdata <= {8'h00, hc_tgt_r};
                    default:            reg_rdata <= 24'h000000;
                endcase
            end
        end
    end

    // Checks
    a_creep_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sample_en && !rd_clear && act_sum == 28'sh0) |=> act_acc_r == $past(act_acc_r))
        else $error("energy moved with all phases gated");
    a_creep_thr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (creep_en && p_flt_r[0] > 24'sh0 && p_flt_r[0] < `EAC_CREEP_THRESH)
        |-> p_gate[0] == 26'sh0)
        else $error("phase below creep threshold not gated");
    a_abs_grow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (abs_mode && sample_en && !rd_clear) |-> act_sum >= 28'sh0)
        else $error("absolute sum went negative");
    a_rev_power: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|p_neg) |=> reverse_power)
        else $error("reverse power missed");
    a_line_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        period_end |=> line_done_r ##1 (irq_n_oe == irqen_r[`EAC_IRQEN_LINE]))
        else $error("line done flag or request wrong");
    a_stat_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (stat_rd && !period_end) |=> !line_done_r)
        else $error("status read did not clear flag");
    a_zc_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(meas_r) |=> zc_enable == $past(meas_r[`EAC_MEAS_ZC_HI:`EAC_MEAS_ZC_LO]))
        else $error("crossing enables not following mode");
    a_line_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
        period_end |=> (line_act_r == 48'sh0 && hc_cnt_r == $past(hc_sum) - 17'($past(hc_tgt_r))))
        else $error("line period did not restart cleanly");
    a_va_unsigned: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (react_mode && sample_en) |-> line_va_add >= 48'sh0)
        else $error("redirected active sum signed");
endmodule : eac_core

// ### tb/eac_host.sv
// Host model driving the register port of the energy block
module eac_host (
    // Clock
    input  wire logic        ref_clk,
    // Register port toward the device
    output logic             reg_wr_en,
    output logic             reg_rd_en,
    output logic [5:0]       reg_addr,
    output logic [7:0]       reg_wdata,
    input  wire logic [23:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 6'h3F;
        reg_wdata = 8'hA5;
    end

    // One write; released lines are inverted so stale values never look valid
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // One read; data taken while the valid pulse stands, bounded wait
    task automatic rd(input logic [5:0] a, output logic [23:0] d, output bit ok);
        int n;
        ok = 1'b0;
        d  = 24'h000000;
        @(negedge ref_clk);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge ref_clk);
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (reg_rvalid === 1'b1)
            begin
                d  = reg_rdata;
                ok = 1'b1;
            end
            else
                @(negedge ref_clk);
        end
    endtask : rd
endmodule : eac_host

// ### tb/tb_energy_accumulation_control.sv
// Self-checking testbench of the energy accumulation control block
`include "eac_cfg.svh"
module tb_energy_accumulation_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic               ref_clk = 1'b0;
    logic               rst_n = 1'b0;
    logic               sample_en = 1'b0;
    logic signed [15:0] vv = '0, ia = '0, ib = '0, ic = '0, sa = '0;
    logic        [2:0]  zc = 3'h0;
    logic               wr_en, rd_en, rvalid, rev_pwr, pls_out, irq_o, irq_oe;
    logic        [5:0]  addr;
    logic        [7:0]  wdata;
    logic        [23:0] rdata;
    logic        [2:0]  zc_en;
    int                 mismatches = 0;
    int                 checks = 0;
    int                 pls_cnt = 0;

    // Clock at 125 MHz
    always #4 ref_clk = ~ref_clk;

    // Pulse counter on the calibration output
    always @(posedge ref_clk)
        if (pls_out === 1'b1)
            pls_cnt <= pls_cnt + 1;

    eac_host u_host (.ref_clk(ref_clk), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));

    eac_core u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .sample_en(sample_en), .volt_a(vv), .volt_b(vv), .volt_c(vv), .curr_a(ia),
        .curr_b(ib), .curr_c(ic), .curr_shift_a(sa), .curr_shift_b(16'sh0000),
        .curr_shift_c(16'sh0000), .apparent_total(24'h000000), .zc_pulse(zc),
        .zc_enable(zc_en), .reverse_power(rev_pwr), .calibration_pulse_out(pls_out),
        .irq_n_o(irq_o), .irq_n_oe(irq_oe));

    // Verdict and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // Comparisons
    task automatic fail(input string msg);
        mismatches++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask : fail
    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string msg);
        checks++;
        if (got !== exp)
            fail(msg);
    endtask : chk_val
    task automatic chk_rng(input logic [23:0] got, input int lo, input int hi, input string msg);
        checks++;
        if ((^got === 1'bx) || (int'(got) < lo) || (int'(got) > hi))
            fail(msg);
    endtask : chk_rng
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp)
            fail(msg);
    endtask : chk_bit

    // Stimulus helpers, all returning at a falling edge
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        bit ok;
        u_host.rd(a, d, ok);
        if (!ok)
        begin
            fail("read answer missing");
            give_verdict();
        end
    endtask : rd
    task automatic run(input int n);
        @(negedge ref_clk);
        sample_en = 1'b1;
        repeat (n) @(negedge ref_clk);
        sample_en = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask : run
    task automatic zcp(input logic [2:0] z);
        @(negedge ref_clk);
        zc = z;
        @(negedge ref_clk);
        zc = 3'h0;
    endtask : zcp
    task automatic wait_oe(input logic exp, input string msg);
        int n;
        for (n = 0; n < 4 && irq_oe !== exp; n++)
            @(negedge ref_clk);
        chk_bit(irq_oe, exp, msg);
        chk_bit(irq_o, 1'b0, "irq level");
    endtask : wait_oe
    task automatic set_count(input logic [7:0] hi, input logic [7:0] lo);
        u_host.wr(`EAC_OFF_HCNT, hi);
        u_host.wr(`EAC_OFF_HCNT, lo);
    endtask : set_count

    // Reset values
    task automatic t_reset();
        logic [23:0] d;
        rd(`EAC_OFF_OPTION, d);
        chk_val(d, 24'h000000, "option reset");
        rd(`EAC_OFF_HCNT, d);
        chk_val(d, 24'h00FFFF, "count reset");
        chk_val({21'h0, zc_en}, 24'h000000, "zc enable reset");
        chk_bit(irq_oe, 1'b0, "irq idle");
        $display("test reset done");
    endtask : t_reset

    // No-load gate just below and well above the threshold
    task automatic t_creep(input logic [7:0] opt, input logic signed [15:0] x,
                           input int lo, input int hi);
        logic [23:0] d;
        u_host.wr(`EAC_OFF_OPTION, opt);
        vv = x;
        ia = x;
        ib = x;
        ic = x;
        rd(`EAC_OFF_ACTRC, d);
        run(12000);
        rd(`EAC_OFF_ACTEN, d);
        chk_rng(d, lo, hi, "no-load gate");
        $display("test creep done");
    endtask : t_creep

    // Phase A forward, phase B reversed, in both summation modes
    task automatic t_sum(input logic [7:0] opt);
        logic [23:0] d, r;
        int          c0;
        u_host.wr(`EAC_OFF_OPTION, opt);
        vv = 16'sd20000;
        ia = 16'sd0;
        ib = 16'sd0;
        ic = 16'sd0;
        run(200);
        rd(`EAC_OFF_ACTRC, d);
        c0 = pls_cnt;
        ia = 16'sd20000;
        ib = -16'sd20000;
        run(64);
        chk_bit(rev_pwr, 1'b1, "reverse power");
        rd(`EAC_OFF_ACTEN, d);
        rd(`EAC_OFF_ACTRC, r);
        chk_val(r, d, "read-clear view");
        if (opt[2])
        begin
            chk_rng(d, 6, 12, "absolute sum");
            chk_rng(24'(pls_cnt - c0), 6, 12, "pulses absolute");
        end
        else
        begin
            chk_rng(d + 24'h1, 0, 1, "signed sum");
            chk_rng(24'(pls_cnt - c0), 0, 2, "pulses signed");
        end
        $display("test sum mode done");
    endtask : t_sum

    // One line period of 100 samples between two phase A crossings
    task automatic line_run(input logic [7:0] wat, input logic signed [15:0] xa, xb, xs,
                            output logic [23:0] la, lva, ae);
        logic [23:0] d;
        ia = 16'sd0;
        ib = 16'sd0;
        sa = 16'sd0;
        run(200);
        u_host.wr(`EAC_OFF_WATT, wat);
        ia = xa;
        ib = xb;
        sa = xs;
        zcp(3'h1);
        rd(`EAC_OFF_ACTRC, d);
        run(100);
        zcp(3'h1);
        rd(`EAC_OFF_LNACT, la);
        rd(`EAC_OFF_LNAPP, lva);
        rd(`EAC_OFF_ACTEN, ae);
    endtask : line_run

    // Combination codes, term selects and line weight
    task automatic t_line();
        logic [23:0] la0, la, lva, a;
        u_host.wr(`EAC_OFF_MEAS, 8'h10);
        set_count(8'h00, 8'h01);
        chk_val({21'h0, zc_en}, 24'h000001, "zc enable A");
        line_run(8'h38, 16'sd20000, 16'sd10000, 16'sd0, la0, lva, a);
        chk_rng(la0, 4 * int'(a) - 4, 4 * int'(a) + 8, "line weight");
        line_run(8'h78, 16'sd20000, 16'sd10000, 16'sd0, la, lva, a);
        chk_rng(la + 24'h1, 0, 2, "code one");
        line_run(8'hB8, 16'sd20000, 16'sd10000, 16'sd0, la, lva, a);
        chk_rng(24'(3 * int'(la)), int'(la0) - 6, int'(la0) + 6, "code two");
        line_run(8'h28, 16'sd20000, 16'sd10000, 16'sd0, la, lva, a);
        chk_rng(24'(3 * int'(la)), 2 * int'(la0) - 8, 2 * int'(la0) + 8, "terms");
        $display("test line done");
    endtask : t_line

    // Reactive mode: active goes unsigned to apparent line accumulator
    task automatic t_react();
        logic [23:0] la, lva, a;
        u_host.wr(`EAC_OFF_WAVE, 8'h20);
        line_run(8'h18, 16'sd20000, -16'sd20000, -16'sd20000, la, lva, a);
        chk_rng(lva, 50, 75, "redirected active");
        chk_bit(la[23], 1'b1, "reactive sign");
        line_run(8'h10, 16'sd20000, -16'sd20000, -16'sd20000, la, lva, a);
        chk_rng(lva, 25, 40, "phase B only");
        chk_rng(la + 24'h1, 0, 2, "reactive B only");
        u_host.wr(`EAC_OFF_WAVE, 8'h00);
        $display("test reactive done");
    endtask : t_react

    // Crossing selection, done flag, interrupt and full 16-bit count
    task automatic t_irq();
        logic [23:0] d;
        u_host.wr(`EAC_OFF_MEAS, 8'h30);
        repeat (2) @(negedge ref_clk);
        chk_val({21'h0, zc_en}, 24'h000003, "zc enable AB");
        set_count(8'h00, 8'h02);
        u_host.wr(`EAC_OFF_IRQEN, 8'h01);
        rd(`EAC_OFF_STATUS, d);
        zcp(3'h4);
        zcp(3'h1);
        repeat (3) @(negedge ref_clk);
        chk_bit(irq_oe, 1'b0, "count not reached");
        zcp(3'h2);
        wait_oe(1'b1, "irq on done");
        rd(`EAC_OFF_STATUS, d);
        chk_bit(d[0], 1'b1, "done flag");
        wait_oe(1'b0, "irq after clear");
        u_host.wr(`EAC_OFF_IRQEN, 8'h00);
        zcp(3'h3);
        repeat (3) @(negedge ref_clk);
        chk_bit(irq_oe, 1'b0, "irq masked");
        rd(`EAC_OFF_STATUS, d);
        chk_bit(d[0], 1'b1, "flag while masked");
        u_host.wr(`EAC_OFF_MEAS, 8'h70);
        set_count(8'hFF, 8'hFF);
        u_host.wr(`EAC_OFF_IRQEN, 8'h01);
        @(negedge ref_clk);
        zc = 3'h7;
        repeat (21844) @(negedge ref_clk);
        zc = 3'h0;
        repeat (3) @(negedge ref_clk);
        chk_bit(irq_oe, 1'b0, "one short of full count");
        zcp(3'h7);
        wait_oe(1'b1, "full count done");
        $display("test interrupt done");
    endtask : t_irq

    // Main sequence
    initial
    begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        t_reset();
        t_creep(8'h00, 16'sd400, 0, 0);
        t_creep(8'h08, 16'sd400, 1, 2);
        t_creep(8'h00, 16'sd600, 2, 4);
        t_sum(8'h04);
        t_sum(8'h00);
        t_line();
        t_react();
        t_irq();
        give_verdict();
    end
endmodule : tb_energy_accumulation_control
